// >>> design/shsw_pkg.sv
package shsw_pkg;
  localparam logic [31:0] SHSW_WAIT_SEL_ADDR = 32'hFFFFF6C0;
  localparam logic [7:0] SHSW_WAIT_SEL_RESET = 8'h06;
  localparam int SHSW_SEL_W = 3;
  localparam logic [2:0] SHSW_SEL_MAX = 3'h6;
  localparam logic [2:0] SHSW_SEL_BAD = 3'h7;
  localparam int SHSW_BASE_EXP = 10;
  localparam int SHSW_CNT_W = 17;
  localparam int SHSW_NIRQ = 15;
  localparam int SHSW_NPERI = 8;
  localparam logic [4:0] SHSW_PRIO_NONE = 5'h1F;
  localparam logic [31:0] SHSW_CTRL_ADDR = 32'h00000000;
  localparam logic [31:0] SHSW_STAT_ADDR = 32'h00000004;
  localparam logic [31:0] SHSW_WSEL_ADDR = 32'h00000008;
  localparam int SHSW_CTRL_HALT = 0;
  localparam int SHSW_CTRL_STOP = 1;
  localparam int SHSW_CTRL_DEEP_IDLE_MODE = 2;
  localparam int SHSW_CTRL_DONE = 3;
  typedef enum logic [1:0] {SHSW_NORMAL, SHSW_HALT, SHSW_OSC_START, SHSW_SETTLE} shsw_mode_t;
endpackage

// >>> design/shsw_if.sv
`timescale 1ns/10ps
`default_nettype none
interface shsw_if;
  logic halt_exec;
  logic stop_release;
  logic deep_idle_mode_release;
  logic osc_running;
  logic [7:0] wsel_wdata;
  logic wsel_we;
  logic wsel_re;
  logic [7:0] wsel_rdata;
  logic nmi_req;
  logic [14:0] ext_irq;
  logic [7:0] peri_irq;
  logic [4:0] req_prio;
  logic [4:0] cur_prio;
  logic reset_src;
  logic cpu_clk_en;
  logic halted;
  logic settling;
  logic wake;
  logic wake_ack;
  logic reset_seq;
  modport dev (input halt_exec, stop_release, deep_idle_mode_release, osc_running, wsel_wdata, wsel_we, wsel_re,
    nmi_req, ext_irq, peri_irq, req_prio, cur_prio, reset_src,
    output wsel_rdata, cpu_clk_en, halted, settling, wake, wake_ack, reset_seq);
  modport core (output halt_exec, stop_release, deep_idle_mode_release, osc_running, wsel_wdata, wsel_we, wsel_re,
    nmi_req, ext_irq, peri_irq, req_prio, cur_prio, reset_src,
    input wsel_rdata, cpu_clk_en, halted, settling, wake, wake_ack, reset_seq);
endinterface
`default_nettype wire

// >>> design/shsw_dev.sv
// Notes on behaviour
// - One select register times stop and deep-idle waits
// - Select register accessed only as byte
// - Reset loads select register with 06
// - Wait is 2^(10+select) oscillator periods
// - Software writes zero to bits three-seven
// - Counting starts once oscillator is running
// - After reset longest wait applies
// - Halt instruction enters halt mode
// - Halt gates only CPU clock
// - Halt stops execution, RAM kept
// - Five NOPs follow halt instruction
// - Pending request: enter halt, leave immediately
// - NMI, unmasked pin or peripheral wakes
// - Any reset source ends halt
// - Release returns to normal mode
// - Lower priority wakes unacknowledged, stays pending
// - Reset release runs normal reset sequence
`timescale 1ns/10ps
`default_nettype none
module shsw_dev (
  input wire logic mclk_i, // Main oscillator clock
  input wire logic rst_i, // Synchronous reset
  shsw_if.dev bus // Core side
);
  typedef struct packed {
    shsw_pkg::shsw_mode_t mode;
    logic [shsw_pkg::SHSW_SEL_W-1:0] sel;
    logic [shsw_pkg::SHSW_CNT_W-1:0] cnt;
    logic [7:0] rdata;
    logic clk_en;
    logic halted;
    logic settling;
    logic wake;
    logic ack;
    logic rst_seq;
  } shsw_dev_st_t;

  shsw_dev_st_t s_q;
  shsw_dev_st_t s_d;
  logic irq_any;
  logic [shsw_pkg::SHSW_CNT_W-1:0] target;

  assign irq_any = bus.nmi_req | (|bus.ext_irq) | (|bus.peri_irq);
  // Final count minus one for the selected exponent
  assign target = shsw_pkg::SHSW_CNT_W'((1 << (shsw_pkg::SHSW_BASE_EXP + int'(s_q.sel))) - 1);

  always_comb
  begin
    s_d = s_q;
    s_d.wake = 1'b0;
    s_d.ack = 1'b0;
    s_d.rst_seq = 1'b0;
    s_d.rdata = 8'h00;
    if (bus.wsel_re)
    begin
      s_d.rdata = {5'h00, s_q.sel};
    end
    if (bus.wsel_we)
    begin
      // Upper bits dropped; value 7 clamped to the longest legal wait
      s_d.sel = (bus.wsel_wdata[2:0] == shsw_pkg::SHSW_SEL_BAD) ? shsw_pkg::SHSW_SEL_MAX
                                                               : bus.wsel_wdata[2:0];
    end
    case (s_q.mode)
      shsw_pkg::SHSW_NORMAL:
      begin
        s_d.clk_en = 1'b1;
        if (bus.halt_exec)
        begin
          s_d.mode = shsw_pkg::SHSW_HALT;
          s_d.clk_en = 1'b0;
          s_d.halted = 1'b1;
        end
        else if (bus.stop_release || bus.deep_idle_mode_release)
        begin
          s_d.mode = shsw_pkg::SHSW_OSC_START;
          s_d.clk_en = 1'b0;
        end
      end
      shsw_pkg::SHSW_HALT:
      begin
        // Pending request seen in the first halt cycle leaves at once
        if (irq_any)
        begin
          s_d.mode = shsw_pkg::SHSW_NORMAL;
          s_d.clk_en = 1'b1;
          s_d.halted = 1'b0;
          s_d.wake = 1'b1;
          s_d.ack = bus.nmi_req || (bus.req_prio < bus.cur_prio);
        end
      end
      shsw_pkg::SHSW_OSC_START:
      begin
        s_d.cnt = '0;
        if (bus.osc_running)
        begin
          s_d.mode = shsw_pkg::SHSW_SETTLE;
          s_d.settling = 1'b1;
        end
      end
      shsw_pkg::SHSW_SETTLE:
      begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == target)
        begin
          s_d.mode = shsw_pkg::SHSW_NORMAL;
          s_d.clk_en = 1'b1;
          s_d.settling = 1'b0;
        end
      end
      default:
      begin
        s_d.mode = shsw_pkg::SHSW_NORMAL;
      end
    endcase
    if (bus.reset_src)
    begin
      // Reset source wins over mode, select and gate flags (a wake in the same cycle still pulses); restart as from power-up
      s_d.mode = shsw_pkg::SHSW_OSC_START;
      s_d.sel = shsw_pkg::SHSW_WAIT_SEL_RESET[2:0];
      s_d.clk_en = 1'b0;
      s_d.halted = 1'b0;
      s_d.settling = 1'b0;
      s_d.rst_seq = 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.mode <= shsw_pkg::SHSW_OSC_START;
      s_q.sel <= shsw_pkg::SHSW_WAIT_SEL_RESET[2:0];
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign bus.wsel_rdata = s_q.rdata;
  assign bus.cpu_clk_en = s_q.clk_en;
  assign bus.halted = s_q.halted;
  assign bus.settling = s_q.settling;
  assign bus.wake = s_q.wake;
  assign bus.wake_ack = s_q.ack;
  assign bus.reset_seq = s_q.rst_seq;
endmodule
`default_nettype wire

// >>> design/shsw_core.sv
`timescale 1ns/10ps
`default_nettype none
module shsw_core (
  input wire logic mclk_i, // Main oscillator clock
  input wire logic rst_i, // Synchronous reset
  shsw_if.core bus, // Device side
  input wire logic [31:0] addr_i, // Register address
  input wire logic [31:0] wdata_i, // Write data
  input wire logic we_i, // Write strobe
  input wire logic re_i, // Read strobe
  output logic [31:0] rdata_o, // Read data, cycle after strobe
  input wire logic osc_running_i, // Oscillator started
  input wire logic nmi_i, // Non-maskable request
  input wire logic [14:0] ext_irq_i, // Unmasked pin requests
  input wire logic [7:0] peri_irq_i, // Unmasked peripheral requests
  input wire logic [4:0] req_prio_i, // Priority of request
  input wire logic [4:0] cur_prio_i, // Priority in service
  input wire logic reset_src_i // Any reset source
);
  typedef struct packed {
    logic [3:0] ctrl;
    logic [31:0] rdata;
    logic rd_wsel;
    logic wake_seen;
  } shsw_core_st_t;

  shsw_core_st_t s_q;
  shsw_core_st_t s_d;
  logic wr_ctrl;
  logic wr_wsel;
  logic rd_wsel;

  assign wr_ctrl = we_i && (addr_i == shsw_pkg::SHSW_CTRL_ADDR);
  assign wr_wsel = we_i && (addr_i == shsw_pkg::SHSW_WSEL_ADDR);
  assign rd_wsel = re_i && (addr_i == shsw_pkg::SHSW_WSEL_ADDR);

  always_comb
  begin
    s_d = s_q;
    s_d.ctrl = 4'h0;
    s_d.rdata = 32'h00000000;
    s_d.rd_wsel = 1'b0;
    if (wr_ctrl)
    begin
      s_d.ctrl = wdata_i[3:0];
    end
    // Wake flag: set wins over clear
    if (wr_ctrl && wdata_i[shsw_pkg::SHSW_CTRL_DONE])
    begin
      s_d.wake_seen = 1'b0;
    end
    if (bus.wake)
    begin
      s_d.wake_seen = 1'b1;
    end
    if (re_i && (addr_i == shsw_pkg::SHSW_STAT_ADDR))
    begin
      s_d.rdata = {27'h0000000, s_q.wake_seen, bus.wake_ack, bus.settling, bus.halted, bus.cpu_clk_en};
    end
    s_d.rd_wsel = rd_wsel;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rd_wsel ? {24'h000000, bus.wsel_rdata} : s_q.rdata;
  assign bus.halt_exec = s_q.ctrl[shsw_pkg::SHSW_CTRL_HALT];
  assign bus.stop_release = s_q.ctrl[shsw_pkg::SHSW_CTRL_STOP];
  assign bus.deep_idle_mode_release = s_q.ctrl[shsw_pkg::SHSW_CTRL_DEEP_IDLE_MODE];
  assign bus.wsel_we = wr_wsel;
  assign bus.wsel_re = rd_wsel;
  // Upper bits always written as zero
  assign bus.wsel_wdata = {5'h00, wdata_i[2:0]};
  assign bus.osc_running = osc_running_i;
  assign bus.nmi_req = nmi_i;
  assign bus.ext_irq = ext_irq_i;
  assign bus.peri_irq = peri_irq_i;
  assign bus.req_prio = req_prio_i;
  assign bus.cur_prio = cur_prio_i;
  assign bus.reset_src = reset_src_i;
endmodule
`default_nettype wire

// >>> dv/shsw_properties.sv
`timescale 1ns/10ps
`default_nettype none
module shsw_properties (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic halt_exec, // Halt instruction
  input wire logic osc_running, // Oscillator up
  input wire logic [7:0] wsel_wdata, // Select write data
  input wire logic wsel_we, // Select write
  input wire logic wsel_re, // Select read
  input wire logic [7:0] wsel_rdata, // Select read data
  input wire logic nmi_req, // Non-maskable
  input wire logic [14:0] ext_irq, // Pin requests
  input wire logic [7:0] peri_irq, // Peripheral requests
  input wire logic [4:0] req_prio, // Request priority
  input wire logic [4:0] cur_prio, // Serviced priority
  input wire logic reset_src, // Reset sources
  input wire logic cpu_clk_en, // CPU clock gate
  input wire logic halted, // In halt
  input wire logic settling, // Wait running
  input wire logic wake, // Released by request
  input wire logic wake_ack, // Request taken
  input wire logic reset_seq // Reset sequence
);
  logic [2:0] sel_q;
  logic [16:0] cnt_q;
  logic req;
  assign req = nmi_req || (|ext_irq) || (|peri_irq);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Mirror of the select field; a write of 7 is held at 6
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || reset_src)
      sel_q <= 3'h6;
    else if (wsel_we)
      sel_q <= (wsel_wdata[2:0] == 3'h7) ? 3'h6 : wsel_wdata[2:0];
    cnt_q <= settling ? cnt_q + 17'h1 : 17'h0;
  end
  halt_enter_a: assert property (halt_exec && cpu_clk_en && !halted && !settling && !reset_src
    |=> halted && !cpu_clk_en) else $error("halt not entered");
  halt_wake_a: assert property (halted && req && !reset_src
    |=> wake && cpu_clk_en && !halted) else $error("halt not released");
  wake_ack_a: assert property (halted && req && !reset_src
    |=> wake_ack == $past(nmi_req || (req_prio < cur_prio))) else $error("wrong acknowledge");
  reset_seq_a: assert property (reset_src |=> reset_seq && !halted && !cpu_clk_en)
    else $error("reset source ignored");
  rdata_val_a: assert property (wsel_rdata == ($past(wsel_re) ? {5'h00, sel_q} : 8'h00))
    else $error("bad select read data");
  osc_hold_a: assert property (!osc_running && !cpu_clk_en && !halted && !settling |=> !cpu_clk_en)
    else $error("clock released without oscillator");
  settle_gate_a: assert property (settling |-> !cpu_clk_en && !halted)
    else $error("clock open while settling");
  settle_len_a: assert property ($fell(settling) && !reset_seq
    |-> cpu_clk_en && cnt_q == (17'h1 << (10 + sel_q))) else $error("wrong settle length");
endmodule
`default_nettype wire

// >>> dv/standby_halt_and_settle_wait_bench.sv
`timescale 1ns/10ps
`default_nettype none
module standby_halt_and_settle_wait_bench;
  typedef struct {logic nmi; logic [14:0] ext; logic [7:0] peri; logic [4:0] rp; logic [4:0] cp; logic ack;} shsw_row_t;
  localparam logic [31:0] CTRL = shsw_pkg::SHSW_CTRL_ADDR;
  localparam logic [31:0] STAT = shsw_pkg::SHSW_STAT_ADDR;
  localparam logic [31:0] WSEL = shsw_pkg::SHSW_WSEL_ADDR;
  logic mclk_i = 1'b0, rst_i = 1'b1, we = 1'b0, re = 1'b0, osc = 1'b0, nmi = 1'b0, rsrc = 1'b0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, d;
  logic [14:0] ext = 15'h0;
  logic [7:0] peri = 8'h00;
  logic [4:0] rp = 5'h00, cp = 5'h00;
  logic ack_seen = 1'b0, seq_seen = 1'b0;
  int mismatches = 0, n_tests = 0, scnt = 0, scnt0 = 0;
  shsw_row_t rows [4] = '{'{1'b1, 15'h0, 8'h00, 5'h1F, 5'h00, 1'b1}, '{1'b0, 15'h4000, 8'h00, 5'h03, 5'h05, 1'b1},
    '{1'b0, 15'h0, 8'h80, 5'h07, 5'h02, 1'b0}, '{1'b0, 15'h0001, 8'h00, 5'h04, 5'h04, 1'b0}};
  shsw_if sif ();
  shsw_dev shsw_dev_i (.mclk_i(mclk_i), .rst_i(rst_i), .bus(sif));
  shsw_core shsw_core_i (.mclk_i(mclk_i), .rst_i(rst_i), .bus(sif), .addr_i(addr), .wdata_i(wdata), .we_i(we),
    .re_i(re), .rdata_o(rdata), .osc_running_i(osc), .nmi_i(nmi), .ext_irq_i(ext), .peri_irq_i(peri),
    .req_prio_i(rp), .cur_prio_i(cp), .reset_src_i(rsrc));
  shsw_properties shsw_properties_i (.mclk_i(mclk_i), .rst_i(rst_i), .halt_exec(sif.halt_exec),
    .osc_running(sif.osc_running), .wsel_wdata(sif.wsel_wdata), .wsel_we(sif.wsel_we), .wsel_re(sif.wsel_re),
    .wsel_rdata(sif.wsel_rdata), .nmi_req(sif.nmi_req), .ext_irq(sif.ext_irq), .peri_irq(sif.peri_irq),
    .req_prio(sif.req_prio), .cur_prio(sif.cur_prio), .reset_src(sif.reset_src), .cpu_clk_en(sif.cpu_clk_en),
    .halted(sif.halted), .settling(sif.settling), .wake(sif.wake), .wake_ack(sif.wake_ack),
    .reset_seq(sif.reset_seq));
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    if (sif.wake)
      ack_seen <= sif.wake_ack;
    if (sif.reset_seq)
      seq_seen <= 1'b1;
    if (sif.settling)
      scnt <= scnt + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge mclk_i);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge mclk_i);
    re <= 1'b0;
    #1 v = rdata;
  endtask
  // Bounded wait; a stuck gate shows up in the following compare
  task automatic wait_en();
    for (int i = 0; i < 70000 && sif.cpu_clk_en !== 1'b1; i++)
      @(negedge mclk_i);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    // About 95k cycles: one long reset wait plus short tests
    #380000;
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(WSEL, d);
    chk(d, 32'h6);
    repeat (19) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(sif.cpu_clk_en, 32'h0);
    @(posedge mclk_i);
    osc <= 1'b1;
    wait_en();
    chk(scnt, 32'd65536);
    $display("reset wait test done");
    wr(WSEL, 32'h7);
    rd(WSEL, d);
    chk(d, 32'h6);
    for (int k = 0; k < 2; k++)
    begin
      wr(WSEL, k);
      scnt0 = scnt;
      // Oscillator held off before the release for k 0 only, so that wait must not start early; for k 1 it stays running
      osc <= k[0];
      wr(CTRL, k ? 32'h4 : 32'h2);
      repeat (13) @(posedge mclk_i);
      osc <= 1'b1;
      wait_en();
      chk(scnt - scnt0, 32'd1024 << k);
      $display("settle test %0d done", k);
    end
    foreach (rows[i])
    begin
      wr(CTRL, 32'h1);
      @(posedge mclk_i);
      rd(STAT, d);
      chk(d[2:0], 32'h2);
      @(posedge mclk_i);
      {nmi, ext, peri, rp, cp} <= {rows[i].nmi, rows[i].ext, rows[i].peri, rows[i].rp, rows[i].cp};
      @(posedge mclk_i);
      {nmi, ext, peri} <= 24'h0;
      rd(STAT, d);
      chk({d[4], d[1:0]}, 32'h5);
      chk(ack_seen, rows[i].ack);
      wr(CTRL, 32'h8);
      $display("halt row %0d done", i);
    end
    @(posedge mclk_i);
    ext <= 15'h0008;
    wr(CTRL, 32'h1);
    repeat (3) @(posedge mclk_i);
    ext <= 15'h0;
    rd(STAT, d);
    chk({d[4], d[1:0]}, 32'h5);
    wr(WSEL, 32'h0);
    wr(CTRL, 32'h1);
    @(posedge mclk_i);
    rsrc <= 1'b1;
    @(posedge mclk_i);
    rsrc <= 1'b0;
    rd(WSEL, d);
    chk(d, 32'h6);
    chk(seq_seen, 32'h1);
    rd(STAT, d);
    chk(d[1:0], 32'h0);
    $display("pending and reset tests done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
